// ---- common/cctm_pkg.sv ----
// constants, types and register map of the capture/compare timer channel
package cctm_pkg;

    // data path widths
    localparam int unsigned CCTM_CNT_W = 16;
    localparam int unsigned CCTM_DATA_W = 32;
    localparam int unsigned CCTM_ADDR_W = 8;
    localparam int unsigned CCTM_PRE_W = 5;

    // register byte offsets
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_RUN = 8'h00;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_MODE = 8'h04;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_FLOP = 8'h08;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_CMPA = 8'h0C;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_CMPB = 8'h10;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_CAPA = 8'h14;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_CAPB = 8'h18;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_CNT = 8'h1C;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_OFF_STAT = 8'h20;
    localparam logic [CCTM_ADDR_W-1:0] CCTM_WORD_MASK = 8'hFC;

    // run_control fields
    localparam int unsigned CCTM_RUN_BIT = 0;
    localparam int unsigned CCTM_DBUF_BIT = 1;
    localparam int unsigned CCTM_CAPNOW_BIT = 2;

    // mode_control fields
    localparam int unsigned CCTM_SRC_LSB = 0;
    localparam int unsigned CCTM_SRC_MSB = 1;
    localparam int unsigned CCTM_FREE_BIT = 2;
    localparam int unsigned CCTM_CAPEDGE_BIT = 3;

    // flop control fields
    localparam int unsigned CCTM_TOGA_BIT = 0;
    localparam int unsigned CCTM_TOGB_BIT = 1;
    localparam int unsigned CCTM_STATE_BIT = 2;
    localparam int unsigned CCTM_LOAD_BIT = 3;

    // reset values and counter limits
    localparam logic [CCTM_CNT_W-1:0] CCTM_CNT_ZERO = 16'h0000;
    localparam logic [CCTM_CNT_W-1:0] CCTM_CNT_ONE = 16'h0001;
    localparam logic [CCTM_CNT_W-1:0] CCTM_CNT_MAX = 16'hFFFF;
    localparam logic [CCTM_CNT_W-1:0] CCTM_CMP_RESET = 16'hFFFF;
    localparam logic [CCTM_DATA_W-1:0] CCTM_DATA_ZERO = 32'h00000000;

    // prescaler terminal masks: divide by 2, 8 and 32
    localparam logic [CCTM_PRE_W-1:0] CCTM_DIV2_MASK = 5'h01;
    localparam logic [CCTM_PRE_W-1:0] CCTM_DIV8_MASK = 5'h07;
    localparam logic [CCTM_PRE_W-1:0] CCTM_DIV32_MASK = 5'h1F;
    localparam logic [CCTM_PRE_W-1:0] CCTM_PRE_ZERO = 5'h00;
    localparam logic [CCTM_PRE_W-1:0] CCTM_PRE_ONE = 5'h01;

    // counter clock source
    typedef enum logic [1:0] {
        CCTM_SRC_DIV2,
        CCTM_SRC_DIV8,
        CCTM_SRC_DIV32,
        CCTM_SRC_EXT
    } cctm_clksrc_t;

    // timer events, status bit order from the msb down
    typedef struct packed {
        logic ovf;
        logic cap_b;
        logic cap_a;
        logic cmp_b;
        logic cmp_a;
    } cctm_events_t;

    // latched ahb address phase
    typedef struct packed {
        logic sel;
        logic write;
        logic [CCTM_ADDR_W-1:0] addr;
    } cctm_ahb_req_t;

endpackage : cctm_pkg

// ---- verilog/cctm_prescaler.sv ----
// prescaler that turns the system clock into counter tick enables
`timescale 1ns/100ps
`default_nettype none
module cctm_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic run,
    input wire cctm_pkg::cctm_clksrc_t sel,
    // one-cycle tick
    output logic tick
);
    import cctm_pkg::*;

    logic [CCTM_PRE_W-1:0] div_reg; // free divider count
    logic [CCTM_PRE_W-1:0] div_next;
    logic tick_reg; // registered tick
    logic tick_next;
    logic [CCTM_PRE_W-1:0] mask; // terminal mask of the chosen rate

    // next divider state and tick
    always_comb
    begin
        unique case (sel)
            CCTM_SRC_DIV2: mask = CCTM_DIV2_MASK;
            CCTM_SRC_DIV8: mask = CCTM_DIV8_MASK;
            CCTM_SRC_DIV32: mask = CCTM_DIV32_MASK;
            CCTM_SRC_EXT: mask = CCTM_DIV2_MASK;
        endcase
        // stopped timer restarts from a clean phase
        div_next = run ? div_reg + CCTM_PRE_ONE : CCTM_PRE_ZERO;
        tick_next = run && (sel != CCTM_SRC_EXT) && ((div_reg & mask) == mask);
    end

    // register divider and tick
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div_reg <= CCTM_PRE_ZERO;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : cctm_prescaler
`default_nettype wire

// ---- verilog/cctm_timer.sv ----
// 16-bit capture/compare timer channel zero with ahb-lite register slave
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cctm_timer (
    // clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [cctm_pkg::CCTM_DATA_W-1:0] HWDATA,
    input wire logic HREADY,
    output logic [cctm_pkg::CCTM_DATA_W-1:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // external pin side
    input wire logic EXTERNAL_COUNT_INPUT,
    output logic SQUARE_WAVE_OUTPUT,
    // event pulses to the interrupt controller
    output logic COMPARE_A_MATCH_IRQ,
    output logic COMPARE_B_MATCH_IRQ,
    output logic CAPTURE_A_IRQ,
    output logic CAPTURE_B_IRQ,
    output logic OVERFLOW_IRQ
);
    import cctm_pkg::*;

    // bus state
    cctm_ahb_req_t dph_reg; // address phase held for data phase
    cctm_ahb_req_t dph_next;
    logic hready_reg; // one wait state per transfer
    logic hready_next;
    logic [CCTM_DATA_W-1:0] hrdata_reg;
    logic [CCTM_DATA_W-1:0] hrdata_next;
    logic accept; // address phase taken
    logic wr; // data phase write
    logic rd; // data phase read

    // control registers
    logic run_reg, run_next;
    logic dbuf_reg, dbuf_next;
    cctm_clksrc_t src_reg, src_next;
    logic free_reg, free_next;
    logic capedge_reg, capedge_next;
    logic tog_a_reg, tog_a_next;
    logic tog_b_reg, tog_b_next;
    logic flop_reg, flop_next; // output toggle flop

    // counter data path
    logic [CCTM_CNT_W-1:0] cnt_reg, cnt_next; // up counter
    logic [CCTM_CNT_W-1:0] cmp_a_reg, cmp_a_next;
    logic [CCTM_CNT_W-1:0] cmp_a_buf_reg, cmp_a_buf_next;
    logic [CCTM_CNT_W-1:0] cmp_b_reg, cmp_b_next;
    logic [CCTM_CNT_W-1:0] cap_a_reg, cap_a_next;
    logic [CCTM_CNT_W-1:0] cap_b_reg, cap_b_next;
    logic ext_prev_reg; // last pin level
    logic ext_rise, ext_fall;
    logic pre_tick; // prescaler enable
    logic tick; // one counter step
    cctm_events_t ev; // events of this cycle
    cctm_events_t status_reg, status_next; // sticky events
    cctm_events_t irq_reg; // registered event pulses
    logic [CCTM_ADDR_W-1:0] wa; // data phase word address

    // prescaled counter clock
    cctm_prescaler cctm_prescaler_inst (
        .clk(MCLK),
        .srst(SRST),
        .run(run_reg),
        .sel(src_reg),
        .tick(pre_tick)
    );

    // bus decode and read mux
    always_comb
    begin
        accept = HSEL && HREADY && HTRANS[1];
        dph_next.sel = accept;
        dph_next.write = HWRITE;
        dph_next.addr = HADDR[CCTM_ADDR_W-1:0] & CCTM_WORD_MASK;
        hready_next = !accept;
        wr = dph_reg.sel && dph_reg.write;
        rd = dph_reg.sel && !dph_reg.write;
        wa = dph_reg.addr;
        hrdata_next = hrdata_reg;
        if (rd)
        begin
            // unmapped offsets read zero
            hrdata_next = CCTM_DATA_ZERO;
            unique case (wa)
                CCTM_OFF_RUN:
                begin
                    hrdata_next[CCTM_RUN_BIT] = run_reg;
                    hrdata_next[CCTM_DBUF_BIT] = dbuf_reg;
                end
                CCTM_OFF_MODE:
                begin
                    hrdata_next[CCTM_SRC_MSB:CCTM_SRC_LSB] = src_reg;
                    hrdata_next[CCTM_FREE_BIT] = free_reg;
                    hrdata_next[CCTM_CAPEDGE_BIT] = capedge_reg;
                end
                CCTM_OFF_FLOP:
                begin
                    hrdata_next[CCTM_TOGA_BIT] = tog_a_reg;
                    hrdata_next[CCTM_TOGB_BIT] = tog_b_reg;
                    hrdata_next[CCTM_STATE_BIT] = flop_reg;
                end
                CCTM_OFF_CMPA: hrdata_next[CCTM_CNT_W-1:0] = cmp_a_reg;
                CCTM_OFF_CMPB: hrdata_next[CCTM_CNT_W-1:0] = cmp_b_reg;
                CCTM_OFF_CAPA: hrdata_next[CCTM_CNT_W-1:0] = cap_a_reg;
                CCTM_OFF_CAPB: hrdata_next[CCTM_CNT_W-1:0] = cap_b_reg;
                CCTM_OFF_CNT: hrdata_next[CCTM_CNT_W-1:0] = cnt_reg;
                CCTM_OFF_STAT: hrdata_next[$bits(cctm_events_t)-1:0] = status_reg;
                default: hrdata_next = CCTM_DATA_ZERO;
            endcase
        end
    end

    // counter, compares, captures, flop and control writes
    always_comb
    begin
        ext_rise = EXTERNAL_COUNT_INPUT && !ext_prev_reg;
        ext_fall = !EXTERNAL_COUNT_INPUT && ext_prev_reg;
        // count step from prescaler or external edge
        tick = run_reg && ((src_reg == CCTM_SRC_EXT) ? ext_rise : pre_tick);
        ev.cmp_a = tick && (cnt_reg == cmp_a_reg);
        ev.cmp_b = tick && (cnt_reg == cmp_b_reg);
        ev.ovf = tick && (cnt_reg == CCTM_CNT_MAX);
        ev.cap_b = capedge_reg && ext_rise;
        ev.cap_a = capedge_reg && ext_fall;
        // hold by default
        run_next = run_reg;
        dbuf_next = dbuf_reg;
        src_next = src_reg;
        free_next = free_reg;
        capedge_next = capedge_reg;
        tog_a_next = tog_a_reg;
        tog_b_next = tog_b_reg;
        flop_next = flop_reg;
        cmp_a_next = cmp_a_reg;
        cmp_a_buf_next = cmp_a_buf_reg;
        cmp_b_next = cmp_b_reg;
        cap_a_next = cap_a_reg;
        cap_b_next = cap_b_reg;
        // counter: stopped clears, interval mode clears at b match
        if (!run_reg)
            cnt_next = CCTM_CNT_ZERO;
        else if (tick && !free_reg && ev.cmp_b)
            cnt_next = CCTM_CNT_ZERO;
        else if (tick)
            cnt_next = cnt_reg + CCTM_CNT_ONE;
        else
            cnt_next = cnt_reg;
        // toggle on enabled matches; both set gives two toggles per period
        if (ev.cmp_a && tog_a_reg)
            flop_next = !flop_next;
        if (ev.cmp_b && tog_b_reg)
            flop_next = !flop_next;
        // buffered compare a moves over at b match
        if (ev.cmp_b && dbuf_reg)
            cmp_a_next = cmp_a_buf_reg;
        // edge captures on channel zero
        if (capedge_reg && ext_rise)
            cap_a_next = cnt_reg;
        if (capedge_reg && ext_fall)
            cap_b_next = cnt_reg;
        // register writes in the data phase
        status_next = status_reg;
        if (wr)
        begin
            unique case (wa)
                CCTM_OFF_RUN:
                begin
                    run_next = HWDATA[CCTM_RUN_BIT];
                    dbuf_next = HWDATA[CCTM_DBUF_BIT];
                    if (HWDATA[CCTM_CAPNOW_BIT])
                        cap_a_next = cnt_reg;
                end
                CCTM_OFF_MODE:
                begin
                    src_next = cctm_clksrc_t'(HWDATA[CCTM_SRC_MSB:CCTM_SRC_LSB]);
                    free_next = HWDATA[CCTM_FREE_BIT];
                    capedge_next = HWDATA[CCTM_CAPEDGE_BIT];
                end
                CCTM_OFF_FLOP:
                begin
                    tog_a_next = HWDATA[CCTM_TOGA_BIT];
                    tog_b_next = HWDATA[CCTM_TOGB_BIT];
                    // initial level sets pulse polarity; write beats a toggle
                    if (HWDATA[CCTM_LOAD_BIT])
                        flop_next = HWDATA[CCTM_STATE_BIT];
                end
                CCTM_OFF_CMPA:
                begin
                    cmp_a_buf_next = HWDATA[CCTM_CNT_W-1:0];
                    if (!dbuf_reg)
                        cmp_a_next = HWDATA[CCTM_CNT_W-1:0];
                end
                CCTM_OFF_CMPB: cmp_b_next = HWDATA[CCTM_CNT_W-1:0];
                CCTM_OFF_STAT:
                begin
                    // write one clears; a new event of this cycle still sets below
                    status_next = status_reg & ~cctm_events_t'(HWDATA[$bits(cctm_events_t)-1:0]);
                end
                default: status_next = status_reg;
            endcase
        end
        // a new event wins over its clear
        status_next = status_next | ev;
    end

    // register all state
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            dph_reg <= '0;
            hready_reg <= 1'b1;
            hrdata_reg <= CCTM_DATA_ZERO;
            run_reg <= 1'b0;
            dbuf_reg <= 1'b0;
            src_reg <= CCTM_SRC_DIV2;
            free_reg <= 1'b0;
            capedge_reg <= 1'b0;
            tog_a_reg <= 1'b0;
            tog_b_reg <= 1'b0;
            flop_reg <= 1'b0;
            cnt_reg <= CCTM_CNT_ZERO;
            cmp_a_reg <= CCTM_CMP_RESET;
            cmp_a_buf_reg <= CCTM_CMP_RESET;
            cmp_b_reg <= CCTM_CMP_RESET;
            cap_a_reg <= CCTM_CNT_ZERO;
            cap_b_reg <= CCTM_CNT_ZERO;
            ext_prev_reg <= 1'b0;
            status_reg <= '0;
            irq_reg <= '0;
        end
        else
        begin
            dph_reg <= dph_next;
            hready_reg <= hready_next;
            hrdata_reg <= hrdata_next;
            run_reg <= run_next;
            dbuf_reg <= dbuf_next;
            src_reg <= src_next;
            free_reg <= free_next;
            capedge_reg <= capedge_next;
            tog_a_reg <= tog_a_next;
            tog_b_reg <= tog_b_next;
            flop_reg <= flop_next;
            cnt_reg <= cnt_next;
            cmp_a_reg <= cmp_a_next;
            cmp_a_buf_reg <= cmp_a_buf_next;
            cmp_b_reg <= cmp_b_next;
            cap_a_reg <= cap_a_next;
            cap_b_reg <= cap_b_next;
            ext_prev_reg <= EXTERNAL_COUNT_INPUT;
            status_reg <= status_next;
            irq_reg <= ev;
        end
    end

    // outputs straight from flops, HRESP tied low
    assign HRDATA = hrdata_reg;
    assign HREADYOUT = hready_reg;
    assign HRESP = 1'b0;
    assign SQUARE_WAVE_OUTPUT = flop_reg;
    assign COMPARE_A_MATCH_IRQ = irq_reg.cmp_a;
    assign COMPARE_B_MATCH_IRQ = irq_reg.cmp_b;
    assign CAPTURE_A_IRQ = irq_reg.cap_a;
    assign CAPTURE_B_IRQ = irq_reg.cap_b;
    assign OVERFLOW_IRQ = irq_reg.ovf;

    // checks on this channel
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    a_stop_clears_count: assert property (!run_reg |=> cnt_reg == CCTM_CNT_ZERO)
        else $error("stopped counter not cleared");
    a_interval_period: assert property (tick && !free_reg && cnt_reg == cmp_b_reg
        |=> cnt_reg == CCTM_CNT_ZERO && COMPARE_B_MATCH_IRQ)
        else $error("interval match did not clear and signal");
    a_event_step: assert property (run_reg && src_reg == CCTM_SRC_EXT && free_reg
        && cnt_reg != CCTM_CNT_MAX |=> cnt_reg == $past(cnt_reg) + {15'h0000, $past(ext_rise)})
        else $error("event counter step wrong");
    a_overflow_wrap: assert property (tick && free_reg && cnt_reg == CCTM_CNT_MAX
        |=> cnt_reg == CCTM_CNT_ZERO && status_reg.ovf && OVERFLOW_IRQ)
        else $error("overflow not flagged");
    a_toggle_on_a: assert property (ev.cmp_a && tog_a_reg && !ev.cmp_b
        && !(wr && wa == CCTM_OFF_FLOP) |=> flop_reg != $past(flop_reg))
        else $error("flop did not toggle at a match");
    a_buffer_load: assert property (ev.cmp_b && dbuf_reg |=> cmp_a_reg == $past(cmp_a_buf_reg))
        else $error("buffered compare not loaded");
    a_capture_rise: assert property (capedge_reg && ext_rise
        |=> cap_a_reg == $past(cnt_reg) && CAPTURE_B_IRQ)
        else $error("rise capture missing");
    a_capture_fall: assert property (capedge_reg && ext_fall
        |=> cap_b_reg == $past(cnt_reg) && CAPTURE_A_IRQ)
        else $error("fall capture missing");
    a_force_zero: assert property (wr && wa == CCTM_OFF_FLOP && HWDATA[CCTM_LOAD_BIT]
        && !HWDATA[CCTM_STATE_BIT] |=> !flop_reg ##1 !flop_reg || tog_a_reg || tog_b_reg)
        else $error("flop not forced low");
    a_bus_wait: assert property (accept |=> !HREADYOUT ##1 HREADYOUT)
        else $error("bus wait state wrong");

    c_interval_match: cover property (COMPARE_B_MATCH_IRQ && !free_reg);
    c_double_buffer: cover property (ev.cmp_b && dbuf_reg);
    c_pulse_width: cover property (CAPTURE_B_IRQ ##[1:200] CAPTURE_A_IRQ);
    c_overflow: cover property (OVERFLOW_IRQ);

endmodule : cctm_timer
`default_nettype wire

// ---- verification/cctm_ext_source.sv ----
// far-side model: external signal source that drives the timer's input pin
`timescale 1ns/100ps
`default_nettype none
module cctm_ext_source (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pulse command from the bench
    input wire logic fire,
    input wire logic [15:0] width,
    // pin level seen by the timer
    output logic pin
);
    logic [15:0] left_reg; // cycles of high level still to go
    logic [15:0] left_next;

    // next value: load width on command, then count down
    always_comb
    begin
        left_next = left_reg;
        if (fire)
            left_next = width;
        else if (left_reg != 16'h0000)
            left_next = left_reg - 16'h0001;
    end

    // register the remaining high time
    always_ff @(posedge clk)
    begin
        if (srst)
            left_reg <= 16'h0000;
        else
            left_reg <= left_next;
    end

    // active-high pulse, low when idle so every pulse gives one rise and one fall
    assign pin = (left_reg != 16'h0000);
endmodule : cctm_ext_source
`default_nettype wire

// ---- verification/cctm_timer_tb.sv ----
// self-checking bench for the capture/compare timer channel
`timescale 1ns/100ps
`default_nettype none
module cctm_timer_tb;
    import cctm_pkg::*;
    // bus and pin drive
    logic mclk, srst, hwrite, fire;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, rd2, hi, npb, nca, ncb, npa, nov;
    logic [15:0] width;
    // design outputs
    logic hreadyout, hresp, pin, sq, irq_pa, irq_pb, irq_ca, irq_cb, irq_ov;
    int error_cnt, comparisons, cycles;

    // 20 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    cctm_timer cctm_timer_inst (.MCLK(mclk), .SRST(srst), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXTERNAL_COUNT_INPUT(pin),
        .SQUARE_WAVE_OUTPUT(sq), .COMPARE_A_MATCH_IRQ(irq_pa), .COMPARE_B_MATCH_IRQ(irq_pb),
        .CAPTURE_A_IRQ(irq_ca), .CAPTURE_B_IRQ(irq_cb), .OVERFLOW_IRQ(irq_ov));

    cctm_ext_source cctm_ext_source_inst (.clk(mclk), .srst(srst), .fire(fire),
        .width(width), .pin(pin));

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one ahb-lite single transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // command one input pulse of w cycles
    task automatic pulse(input logic [15:0] w);
        @(posedge mclk);
        width <= w;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask : pulse

    // wait, bounded, for a compare b event pulse
    task automatic wait_b();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (irq_pb !== 1'b1 && n < 500);
        check({31'h0, irq_pb}, 32'h1);
    endtask : wait_b

    // watch n cycles: high time of the output and event pulse counts
    task automatic watch(input int n);
        hi = 0;
        npb = 0;
        nca = 0;
        ncb = 0;
        npa = 0;
        nov = 0;
        repeat (n)
        begin
            @(posedge mclk);
            hi += {31'h0, sq === 1'b1};
            npa += {31'h0, irq_pa === 1'b1};
            nov += {31'h0, irq_ov === 1'b1};
            npb += {31'h0, irq_pb === 1'b1};
            nca += {31'h0, irq_ca === 1'b1};
            ncb += {31'h0, irq_cb === 1'b1};
        end
    endtask : watch

    // reset values and an unmapped place
    task automatic s_reset();
        bus(0, CCTM_OFF_CNT, 0);
        check(rd, 32'h0);
        bus(0, CCTM_OFF_CMPB, 0);
        check(rd, 32'h0000FFFF);
        bus(0, 8'h24, 0);
        check(rd, 32'h0);
        check({31'h0, hresp}, 32'h0);
    endtask : s_reset

    // interval mode: period of cmpb+1 ticks at divide by 2, then stop
    task automatic s_interval();
        bus(1, CCTM_OFF_MODE, 32'h0);
        bus(1, CCTM_OFF_CMPB, 32'h4);
        bus(1, CCTM_OFF_FLOP, 32'hA);
        bus(1, CCTM_OFF_RUN, 32'h1);
        wait_b();
        watch(100);
        check(npb, 32'hA);
        bus(0, CCTM_OFF_STAT, 0);
        check(rd & 32'h2, 32'h2);
        bus(1, CCTM_OFF_RUN, 32'h0);
        bus(0, CCTM_OFF_CNT, 0);
        check(rd, 32'h0);
        bus(1, CCTM_OFF_STAT, 32'h1F);
        bus(0, CCTM_OFF_STAT, 0);
        check(rd, 32'h0);
    endtask : s_interval

    // event counting on input rises, read through the capture command
    task automatic s_event();
        bus(1, CCTM_OFF_MODE, 32'h7);
        bus(1, CCTM_OFF_RUN, 32'h1);
        repeat (5)
        begin
            pulse(16'h0003);
            repeat (5) @(posedge mclk);
        end
        bus(1, CCTM_OFF_RUN, 32'h5);
        bus(0, CCTM_OFF_CAPA, 0);
        check(rd, 32'h5);
        bus(1, CCTM_OFF_RUN, 32'h0);
    endtask : s_event

    // pulse mode, both toggles, given start level; then forced low
    task automatic s_ppg(input logic lvl);
        bus(1, CCTM_OFF_MODE, 32'h0);
        bus(1, CCTM_OFF_CMPA, 32'h1);
        bus(1, CCTM_OFF_CMPB, 32'h5);
        bus(1, CCTM_OFF_FLOP, {28'h0, 1'b1, lvl, 2'b11});
        bus(1, CCTM_OFF_RUN, 32'h1);
        wait_b();
        watch(120);
        check(hi, lvl ? 32'd40 : 32'd80);
        check(npb, 32'hA);
        bus(1, CCTM_OFF_FLOP, 32'h8);
        watch(60);
        check(hi, 32'h0);
        bus(1, CCTM_OFF_RUN, 32'h0);
    endtask : s_ppg

    // buffered compare a takes the new value only at the b match
    task automatic s_dbuf();
        bus(1, CCTM_OFF_MODE, 32'h2);
        bus(1, CCTM_OFF_CMPA, 32'h1);
        bus(1, CCTM_OFF_CMPB, 32'h5);
        bus(1, CCTM_OFF_RUN, 32'h3);
        wait_b();
        bus(1, CCTM_OFF_CMPA, 32'h3);
        bus(0, CCTM_OFF_CMPA, 0);
        check(rd, 32'h1);
        wait_b();
        bus(0, CCTM_OFF_CMPA, 0);
        check(rd, 32'h3);
        bus(1, CCTM_OFF_RUN, 32'h0);
    endtask : s_dbuf

    // pulse width: capture a on rise, b on fall, free-running at divide by 8
    task automatic s_width();
        bus(1, CCTM_OFF_MODE, 32'hD);
        bus(1, CCTM_OFF_RUN, 32'h1);
        pulse(16'd40);
        watch(60);
        check(nca, 32'h1);
        check(ncb, 32'h1);
        check(nov, 32'h0);
        bus(0, CCTM_OFF_CAPA, 0);
        rd2 = rd;
        bus(0, CCTM_OFF_CAPB, 0);
        check(rd - rd2, 32'h5);
        bus(1, CCTM_OFF_RUN, 32'h0);
    endtask : s_width

    // one-shot after a trigger: compares from the capture, toggles off at the end
    task automatic s_oneshot();
        bus(1, CCTM_OFF_FLOP, 32'h8);
        bus(1, CCTM_OFF_MODE, 32'hC);
        bus(1, CCTM_OFF_RUN, 32'h1);
        pulse(16'h0004);
        watch(4);
        check(ncb, 32'h1);
        bus(0, CCTM_OFF_CAPA, 0);
        rd2 = rd;
        // delay of 32 ticks, then a width of 16 ticks
        bus(1, CCTM_OFF_CMPA, rd2 + 32'h20);
        bus(1, CCTM_OFF_CMPB, rd2 + 32'h30);
        bus(1, CCTM_OFF_FLOP, 32'h3);
        watch(150);
        check(hi, 32'h20);
        check(npa, 32'h1);
        check(npb, 32'h1);
        bus(1, CCTM_OFF_FLOP, 32'h0);
        bus(0, CCTM_OFF_FLOP, 0);
        check(rd, 32'h0);
        bus(1, CCTM_OFF_RUN, 32'h0);
    endtask : s_oneshot

    // report and verdict
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // main sequence
    initial
    begin
        srst = 1'b1;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        fire = 1'b0;
        width = 16'h0;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        s_reset();
        s_interval();
        s_event();
        s_ppg(1'b0);
        s_ppg(1'b1);
        s_dbuf();
        s_width();
        s_oneshot();
        complete_run();
    end
endmodule : cctm_timer_tb
`default_nettype wire
